// >>> hw/debug_comparator_match.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module debug_comparator_match
    import dbg_cmp_pkg::*;
(
    // Clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_i,
    // Register port
    input  wire logic [dbg_cmp_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [dbg_cmp_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [dbg_cmp_pkg::DATA_W-1:0] reg_rdata_o,
    // CPU bus
    input  wire logic                          cpu_valid_i,
    input  wire logic [17:0]                   cpu_addr_i,
    input  wire logic [15:0]                   cpu_data_i,
    input  wire logic                          cpu_read_i,
    input  wire logic                          cpu_byte_i,
    // Instruction queue
    input  wire logic                          fetch_valid_i,
    input  wire logic [17:0]                   fetch_addr_i,
    input  wire logic                          exec_valid_i,
    input  wire logic [17:0]                   exec_addr_i,
    input  wire logic                          queue_flush_i,
    // Match results
    output logic      [dbg_cmp_pkg::NUM_CH-1:0] match_o,
    output logic                               seq_event_o,
    output logic      [1:0]                    seq_channel_o,
    output logic                               break_o,
    output logic                               trace_stop_o,
    output logic                               armed_o,
    // Interrupt
    output logic                               irq_o
);
    import dbg_cmp_pkg::*;

    typedef struct packed {
        logic [NUM_CH-1:0][7:0] ctl;
        logic [NUM_CH-1:0][7:0] addr_high;
        logic [NUM_CH-1:0][7:0] addr_mid;
        logic [NUM_CH-1:0][7:0] addr_low;
        logic [15:0]            data_val;
        logic [15:0]            data_mask;
        logic [7:0]             c1;
        logic [NUM_CH-1:0]      tag_pend;
        logic [NUM_CH-1:0]      match;
        logic                   seq_event;
        logic [1:0]             seq_ch;
        logic                   immediate_end_select;
        logic                   tstop;
        logic [IRQ_W-1:0]       status;
        logic [IRQ_W-1:0]       mask;
        logic [7:0]             rdata;
    } state_t;

    state_t s;
    state_t next_s;

    function automatic logic [7:0] ctl_mask(input int unsigned ch);
        begin
            ctl_mask = (ch == 0) ? CTL_MASK_A : ((ch == 1) ? CTL_MASK_B : CTL_MASK_C);
        end
    endfunction

    function automatic logic [17:0] cmp_addr(input state_t st, input int unsigned ch);
        begin
            cmp_addr = {st.addr_high[ch][1:0], st.addr_mid[ch], st.addr_low[ch]};
        end
    endfunction

    // Untagged qualifiers; the caller only applies these when tag is clear
    function automatic logic qual_ok(input state_t st, input int unsigned ch,
                                     input logic [15:0] data, input logic rd, input logic byte_acc);
        logic [7:0] c;
        logic       ok;
        logic       deq;
        begin
            c   = st.ctl[ch];
            ok  = 1'b1;
            deq = ((data ^ st.data_val) & st.data_mask) == 16'h0000;
            if (c[CTL_DIR_CMP_EN] && (c[CTL_DIR_VALUE] != rd))
                ok = 1'b0;
            if (ch == 0 && (c[CTL_BIT6] ? deq : !deq))
                ok = 1'b0;
            if (ch == 1 && c[CTL_WIDTH_CMP_EN] && (c[CTL_BIT6] != byte_acc))
                ok = 1'b0;
            qual_ok = ok;
        end
    endfunction

    always_comb
    begin
        logic              armed;
        logic [1:0]        bank;
        logic              win_ok;
        logic [NUM_CH-1:0] hit;
        logic              end_now;
        logic [7:0]        rd;
        int unsigned       wch;
        armed   = s.c1[C1_ARM_BIT];
        bank    = s.c1[C1_BANK_LSB +: 2];
        win_ok  = (bank != BANK_NONE);
        hit     = '0;
        end_now = 1'b0;
        rd      = 8'h00;
        wch     = 32'(bank);
        next_s  = s;

        next_s.seq_event = 1'b0;
        next_s.immediate_end_select       = 1'b0;
        next_s.tstop     = 1'b0;

        // Channel matching
        for (int unsigned ch = 0; ch < NUM_CH; ch++)
        begin
            if (s.ctl[ch][CTL_ON] && armed)
            begin
                if (!s.ctl[ch][CTL_TAG])
                begin
                    hit[ch] = cpu_valid_i && (cpu_addr_i == cmp_addr(s, ch))
                              && qual_ok(s, ch, cpu_data_i, cpu_read_i, cpu_byte_i);
                end
                else
                begin
                    // Qualifiers deliberately not consulted here
                    hit[ch] = s.tag_pend[ch] && exec_valid_i && (exec_addr_i == cmp_addr(s, ch));
                    if (fetch_valid_i && (fetch_addr_i == cmp_addr(s, ch)))
                        next_s.tag_pend[ch] = 1'b1;
                end
            end
            if (hit[ch] || queue_flush_i || !armed || !s.ctl[ch][CTL_TAG])
                next_s.tag_pend[ch] = hit[ch] ? 1'b0 : (next_s.tag_pend[ch] && !queue_flush_i && armed
                                                        && s.ctl[ch][CTL_TAG]);
            if (hit[ch] && s.ctl[ch][CTL_IMM_END])
                end_now = 1'b1;
        end
        next_s.match = hit;

        // Lowest channel wins the sequencer event
        next_s.seq_event = |hit;
        next_s.seq_ch    = hit[0] ? 2'h0 : (hit[1] ? 2'h1 : 2'h2);

        // Register writes; hardware end of session is applied afterwards
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                OFS_DEBUG_CONTROL_ONE:
                    next_s.c1 = reg_wdata_i & C1_WRITE_MASK;
                OFS_CMP_CONTROL:
                    if (win_ok && !armed)
                        next_s.ctl[wch] = reg_wdata_i & ctl_mask(wch);
                OFS_CMP_ADDR_HIGH:
                    if (win_ok && !armed)
                        next_s.addr_high[wch] = reg_wdata_i & ADDR_HIGH_MASK;
                OFS_CMP_ADDR_MID:
                    if (win_ok && !armed)
                        next_s.addr_mid[wch] = reg_wdata_i;
                OFS_CMP_ADDR_LOW:
                    if (win_ok && !armed)
                        next_s.addr_low[wch] = reg_wdata_i;
                OFS_CMP_DATA_HIGH:
                    if (bank == BANK_A && !armed)
                        next_s.data_val[15:8] = reg_wdata_i;
                OFS_CMP_DATA_LOW:
                    if (bank == BANK_A && !armed)
                        next_s.data_val[7:0] = reg_wdata_i;
                OFS_CMP_MASK_HIGH:
                    if (bank == BANK_A && !armed)
                        next_s.data_mask[15:8] = reg_wdata_i;
                OFS_CMP_MASK_LOW:
                    if (bank == BANK_A && !armed)
                        next_s.data_mask[7:0] = reg_wdata_i;
                OFS_IRQ_STATUS:
                    next_s.status = s.status & ~reg_wdata_i[IRQ_W-1:0];
                OFS_IRQ_MASK:
                    next_s.mask = reg_wdata_i[IRQ_W-1:0];
                default:
                    ;
            endcase
        end

        // Immediate end of session
        if (end_now)
        begin
            next_s.c1[C1_ARM_BIT] = 1'b0;
            next_s.tstop          = 1'b1;
            next_s.immediate_end_select            = s.c1[C1_BRK_GLOBAL_BIT];
        end

        // Sticky events, set beats a same-cycle clear
        next_s.status = next_s.status | {end_now, hit};

        // Register reads, data one cycle later
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                OFS_DEBUG_CONTROL_ONE: rd = s.c1;
                OFS_CMP_CONTROL:       rd = win_ok ? s.ctl[wch] : 8'h00;
                OFS_CMP_ADDR_HIGH:     rd = win_ok ? s.addr_high[wch] : 8'h00;
                OFS_CMP_ADDR_MID:      rd = win_ok ? s.addr_mid[wch] : 8'h00;
                OFS_CMP_ADDR_LOW:      rd = win_ok ? s.addr_low[wch] : 8'h00;
                OFS_CMP_DATA_HIGH:     rd = (bank == BANK_A) ? s.data_val[15:8] : 8'h00;
                OFS_CMP_DATA_LOW:      rd = (bank == BANK_A) ? s.data_val[7:0] : 8'h00;
                OFS_CMP_MASK_HIGH:     rd = (bank == BANK_A) ? s.data_mask[15:8] : 8'h00;
                OFS_CMP_MASK_LOW:      rd = (bank == BANK_A) ? s.data_mask[7:0] : 8'h00;
                OFS_IRQ_STATUS:        rd = {{(8-IRQ_W){1'b0}}, s.status};
                OFS_IRQ_MASK:          rd = {{(8-IRQ_W){1'b0}}, s.mask};
                default:               rd = 8'h00;
            endcase
        end
        next_s.rdata = rd;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign reg_rdata_o   = s.rdata;
    assign match_o       = s.match;
    assign seq_event_o   = s.seq_event;
    assign seq_channel_o = s.seq_ch;
    assign break_o       = s.immediate_end_select;
    assign trace_stop_o  = s.tstop;
    assign armed_o       = s.c1[C1_ARM_BIT];
    // Level output so a missed edge cannot lose an event
    assign irq_o         = |(s.status & s.mask);

endmodule

// >>> hw/dbg_cmp_pkg.sv
package dbg_cmp_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CH = 3;

    // Register offsets
    localparam logic [7:0] OFS_DEBUG_CONTROL_ONE = 8'h20;
    localparam logic [7:0] OFS_CMP_CONTROL       = 8'h28;
    localparam logic [7:0] OFS_CMP_ADDR_HIGH     = 8'h29;
    localparam logic [7:0] OFS_CMP_ADDR_MID      = 8'h2A;
    localparam logic [7:0] OFS_CMP_ADDR_LOW      = 8'h2B;
    localparam logic [7:0] OFS_CMP_DATA_HIGH     = 8'h2C;
    localparam logic [7:0] OFS_CMP_DATA_LOW      = 8'h2D;
    localparam logic [7:0] OFS_CMP_MASK_HIGH     = 8'h2E;
    localparam logic [7:0] OFS_CMP_MASK_LOW      = 8'h2F;
    localparam logic [7:0] OFS_IRQ_STATUS        = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK          = 8'h31;

    // debug_control_one fields
    localparam int unsigned C1_ARM_BIT         = 7;
    localparam int unsigned C1_BRK_GLOBAL_BIT  = 4;
    localparam int unsigned C1_BANK_LSB        = 0;
    localparam logic [7:0]  C1_WRITE_MASK      = 8'h93;

    // comparator_control fields
    localparam int unsigned CTL_WIDTH_CMP_EN   = 7;
    localparam int unsigned CTL_BIT6           = 6;
    localparam int unsigned CTL_TAG            = 5;
    localparam int unsigned CTL_IMM_END        = 4;
    localparam int unsigned CTL_DIR_VALUE      = 3;
    localparam int unsigned CTL_DIR_CMP_EN     = 2;
    localparam int unsigned CTL_ON             = 0;

    // Implemented control bits per comparator A, B, C
    localparam logic [7:0] CTL_MASK_A = 8'h7D;
    localparam logic [7:0] CTL_MASK_B = 8'hFD;
    localparam logic [7:0] CTL_MASK_C = 8'h3D;

    localparam logic [7:0] ADDR_HIGH_MASK = 8'h03;

    // Bank select codes
    localparam logic [1:0] BANK_A    = 2'h0;
    localparam logic [1:0] BANK_B    = 2'h1;
    localparam logic [1:0] BANK_C    = 2'h2;
    localparam logic [1:0] BANK_NONE = 2'h3;

    // Interrupt status layout: [2:0] channel match, [3] session ended
    localparam int unsigned IRQ_END_BIT  = 3;
    localparam int unsigned IRQ_W        = 4;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;

endpackage

// >>> verification/debug_comparator_match_monitor.sv
`timescale 1ns/1ps
module debug_comparator_match_monitor
    import dbg_cmp_pkg::*;
(
    // Clock and reset
    input wire logic                           core_clk_i,
    input wire logic                           rst_i,
    // Register port
    input wire logic                           reg_rd_i,
    input wire logic                           reg_wr_i,
    input wire logic [dbg_cmp_pkg::DATA_W-1:0] reg_rdata_o,
    // Bus qualifiers
    input wire logic                           cpu_valid_i,
    input wire logic                           exec_valid_i,
    // Results
    input wire logic [dbg_cmp_pkg::NUM_CH-1:0] match_o,
    input wire logic                           seq_event_o,
    input wire logic [1:0]                     seq_channel_o,
    input wire logic                           break_o,
    input wire logic                           trace_stop_o,
    input wire logic                           armed_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    event_any_a: assert property (seq_event_o == (match_o != 3'h0))
        else $error("event flag disagrees with match vector");
    channel_prio_a: assert property (seq_event_o |-> seq_channel_o == (match_o[0] ? 2'h0 : match_o[1] ? 2'h1 : 2'h2))
        else $error("winning channel is not the lowest");
    match_armed_a: assert property (match_o != 3'h0 |-> $past(armed_o))
        else $error("match while not armed");
    match_cause_a: assert property (match_o != 3'h0 |-> $past(cpu_valid_i) || $past(exec_valid_i))
        else $error("match without a bus cycle or execution");
    break_trace_a: assert property (break_o |-> trace_stop_o)
        else $error("break without session end");
    stop_disarm_a: assert property (trace_stop_o |-> !armed_o && seq_event_o)
        else $error("session end left module armed");
    disarm_cause_a: assert property ($fell(armed_o) |-> trace_stop_o || $past(reg_wr_i))
        else $error("disarm without cause");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");

    cover property (match_o == 3'h3);
    cover property (break_o);
    cover property (trace_stop_o && !break_o);
endmodule

bind debug_comparator_match debug_comparator_match_monitor i_mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .cpu_valid_i(cpu_valid_i),
    .exec_valid_i(exec_valid_i), .match_o(match_o), .seq_event_o(seq_event_o), .seq_channel_o(seq_channel_o),
    .break_o(break_o), .trace_stop_o(trace_stop_o), .armed_o(armed_o));

// >>> verification/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
    // Clock
    input  wire logic   core_clk_i,
    // Data bus
    output logic        cpu_valid_o,
    output logic [17:0] cpu_addr_o,
    output logic [15:0] cpu_data_o,
    output logic        cpu_read_o,
    output logic        cpu_byte_o,
    // Instruction queue
    output logic        fetch_valid_o,
    output logic        exec_valid_o,
    output logic [17:0] q_addr_o
);
    initial {cpu_valid_o, cpu_addr_o, cpu_data_o, cpu_read_o, cpu_byte_o} = 37'h0;
    initial {fetch_valid_o, exec_valid_o, q_addr_o} = 20'h0;

    // Released lines show the inverse so stale values never match by accident
    task automatic cyc(input logic [17:0] a, input logic [15:0] d, input logic rd, input logic byt);
        @(posedge core_clk_i);
        {cpu_valid_o, cpu_addr_o, cpu_data_o, cpu_read_o, cpu_byte_o} <= {1'b1, a, d, rd, byt};
        @(posedge core_clk_i);
        {cpu_valid_o, cpu_addr_o, cpu_data_o, cpu_read_o, cpu_byte_o} <= {1'b0, ~a, ~d, ~rd, ~byt};
    endtask

    task automatic q(input logic f, input logic [17:0] a);
        @(posedge core_clk_i);
        {fetch_valid_o, exec_valid_o, q_addr_o} <= {f, ~f, a};
        @(posedge core_clk_i);
        {fetch_valid_o, exec_valid_o, q_addr_o} <= {2'h0, ~a};
    endtask
endmodule

// >>> verification/debug_comparator_match_tb.sv
`timescale 1ns/1ps
module debug_comparator_match_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  ra = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [7:0]  rdat;
    logic        cv, crd, cby, fv, ev, sev, immediate_end_select, tstop, armed, irq;
    logic [17:0] ca, qa;
    logic [15:0] cd;
    logic [2:0]  match;
    logic [1:0]  sch;
    logic        flush = 1'b0;
    int          bad_count = 0;
    int          tests_run = 0;

    debug_comparator_match i_dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(wd),
        .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdat), .cpu_valid_i(cv), .cpu_addr_i(ca), .cpu_data_i(cd),
        .cpu_read_i(crd), .cpu_byte_i(cby), .fetch_valid_i(fv), .fetch_addr_i(qa), .exec_valid_i(ev),
        .exec_addr_i(qa), .queue_flush_i(flush), .match_o(match), .seq_event_o(sev), .seq_channel_o(sch),
        .break_o(immediate_end_select), .trace_stop_o(tstop), .armed_o(armed), .irq_o(irq));
    cpu_bus_model i_cpu (.core_clk_i(clk), .cpu_valid_o(cv), .cpu_addr_o(ca), .cpu_data_o(cd),
        .cpu_read_o(crd), .cpu_byte_o(cby), .fetch_valid_o(fv), .exec_valid_o(ev), .q_addr_o(qa));

    task automatic chk(input string n, input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {we, ra, wd} <= {1'b1, a, d};
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        {re, ra} <= {1'b1, a};
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk("reg_rdata_o", rdat, exp);
    endtask
    task automatic hit(input logic [17:0] a, input logic r, input logic b, input logic [2:0] exp);
        i_cpu.cyc(a, 16'h1234, r, b);
        #1;
        chk("match_o", match, exp);
    endtask
    // Every reconfiguration disarms first, since armed writes are dropped
    task automatic setc(input logic [1:0] b, input logic [7:0] ctl, input logic [7:0] c1);
        wr(8'h20, {6'h00, b});
        wr(8'h28, ctl);
        wr(8'h20, c1 | {6'h00, b});
    endtask
    function automatic logic [17:0] adr(input int b);
        return {2'(b), 8'(8'h40 + b), 8'h3C};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial forever #5 clk = ~clk;
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(8'h2A, 8'h00);
        for (int b = 0; b < 3; b++)
        begin
            wr(8'h20, 8'(b));
            wr(8'h28, 8'h01);
            wr(8'h29, 8'hFC | 8'(b));
            wr(8'h2A, 8'h40 + 8'(b));
            wr(8'h2B, 8'h3C);
        end
        for (int b = 0; b < 3; b++)
        begin
            wr(8'h20, 8'(b));
            rd(8'h29, 8'(b));
            rd(8'h2A, 8'h40 + 8'(b));
        end
        wr(8'h20, 8'h03);
        wr(8'h2A, 8'h77);
        rd(8'h2A, 8'h00);
        wr(8'h20, 8'h83);
        hit(adr(0), 1'b0, 1'b0, 3'h1);
        chk("seq_channel_o", sch, 2'h0);
        chk("seq_event_o", sev, 1'b1);
        hit(adr(1), 1'b0, 1'b0, 3'h2);
        hit(adr(2), 1'b0, 1'b0, 3'h4);
        hit(adr(0) ^ 18'h10000, 1'b0, 1'b0, 3'h0);
        hit(adr(0) ^ 18'h00100, 1'b0, 1'b0, 3'h0);
        hit(adr(0) ^ 18'h00001, 1'b0, 1'b0, 3'h0);
        wr(8'h20, 8'h81);
        wr(8'h2A, 8'hEE);
        wr(8'h28, 8'h00);
        rd(8'h2A, 8'h41);
        rd(8'h28, 8'h01);
        rd(8'h30, 8'h07);
        wr(8'h31, 8'h02);
        chk("irq_o", irq, 1'b1);
        wr(8'h30, 8'h02);
        chk("irq_o", irq, 1'b0);
        wr(8'h31, 8'h00);
        setc(2'h1, 8'hC1, 8'h80);
        hit(adr(1), 1'b1, 1'b0, 3'h0);
        hit(adr(1), 1'b1, 1'b1, 3'h2);
        setc(2'h1, 8'h41, 8'h80);
        hit(adr(1), 1'b1, 1'b0, 3'h2);
        setc(2'h2, 8'h0D, 8'h80);
        hit(adr(2), 1'b0, 1'b0, 3'h0);
        hit(adr(2), 1'b1, 1'b0, 3'h4);
        setc(2'h2, 8'h09, 8'h80);
        hit(adr(2), 1'b0, 1'b0, 3'h4);
        setc(2'h2, 8'h00, 8'h80);
        hit(adr(2), 1'b1, 1'b0, 3'h0);
        setc(2'h0, 8'h41, 8'h80);
        hit(adr(0), 1'b0, 1'b0, 3'h0);
        setc(2'h0, 8'h6D, 8'h80);
        hit(adr(0), 1'b1, 1'b0, 3'h0);
        i_cpu.q(1'b1, adr(0));
        i_cpu.q(1'b0, adr(0));
        #1;
        chk("match_o", match, 3'h1);
        // Flush between fetch and execution drops the tag
        i_cpu.q(1'b1, adr(0));
        @(posedge clk);
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
        i_cpu.q(1'b0, adr(0));
        #1;
        chk("match_o", match, 3'h0);
        setc(2'h0, 8'h11, 8'h90);
        hit(adr(0), 1'b0, 1'b0, 3'h1);
        chk("break_o", immediate_end_select, 1'b1);
        chk("armed_o", armed, 1'b0);
        setc(2'h0, 8'h11, 8'h80);
        hit(adr(0), 1'b0, 1'b0, 3'h1);
        chk("break_o", immediate_end_select, 1'b0);
        chk("trace_stop_o", tstop, 1'b1);
        setc(2'h0, 8'h01, 8'h00);
        wr(8'h20, 8'h01);
        wr(8'h29, 8'h00);
        wr(8'h2A, 8'h40);
        wr(8'h20, 8'h81);
        hit(adr(0), 1'b0, 1'b0, 3'h3);
        chk("seq_channel_o", sch, 2'h0);
        report_and_stop();
    end
endmodule
